// ---- rtl/port_pins_pkg.sv ----
package port_pins_pkg;
	localparam int PORT_WIDTH     = 8;
	localparam int NIBBLE_WIDTH   = 4;
	localparam int STRONG_CLOCKS  = 2;
	localparam logic [7:0] LATCH_RESET = 8'hff;
	localparam logic [3:0] NIBBLE_RESET = 4'hf;
	localparam logic [1:0] STRONG_CNT_W1 = 2'(STRONG_CLOCKS - 1);
	// Fourth port bit positions
	localparam int BIT_RXD   = 0;
	localparam int BIT_TXD   = 1;
	localparam int BIT_IRQ0  = 2;
	localparam int BIT_IRQ1  = 3;
	localparam int BIT_TMR0  = 4;
	localparam int BIT_TMR1  = 5;
	localparam int BIT_WRN   = 6;
	localparam int BIT_RDN   = 7;
	// Second port bit positions
	localparam int BIT_T2    = 0;
	localparam int BIT_TIMER2_EXT_CONTROL_PIN  = 1;
	// Extra port wake bits
	localparam int BIT_WAKE2 = 2;
	localparam int BIT_WAKE3 = 3;
	// Machine cycle lengths
	localparam logic [3:0] CYCLE_12 = 4'hc;
	localparam logic [3:0] CYCLE_6  = 4'h6;
	typedef enum logic {BUS_ADDR, BUS_DATA} bus_phase_t;
endpackage

// ---- rtl/quasi_bidir_port_pins.sv ----
`timescale 1ns/1ps
// Function
// [RQ1] First port open-drain, ones float
// [RQ2] First port muxes low address, data
// [RQ3] Written one: strong high two clocks
// [RQ4] Third port GPIO or high address
// [RQ5] Second port bit0 timer2 event/clkout
// [RQ6] Second port bit1 timer2 control input
// [RQ7] Fourth port bits0/1 UART rx/tx
// [RQ8] Machine cycle 12 or 6 clocks
// [RQ9] Power-down wake from four pins
// [RQ10] Fourth port irq and timer inputs
// [RQ11] Fourth port bits6/7 write/read strobes
// [RQ12] Pin reads return synchronised pad level
module quasi_bidir_port_pins #(
	parameter int W = port_pins_pkg::PORT_WIDTH
) (
	input  wire logic         sys_clk,
	input  wire logic         rst,
	input  wire logic         sixClockMode,
	output logic [3:0]        machineCycleLen,
	input  wire logic         latchWrite,
	input  wire logic [1:0]   latchSel,
	input  wire logic [W-1:0] latchData,
	input  wire logic [3:0]   nibbleData,
	input  wire logic         nibbleWrite,
	input  wire logic         extBusActive,
	input  wire logic         busDataPhase,
	input  wire logic         busDataDrive,
	input  wire logic [7:0]   busAddrLow,
	input  wire logic [7:0]   busAddrHigh,
	input  wire logic [7:0]   busDataOut,
	input  wire logic         extDataAccess,
	input  wire logic         busWriteStrobe,
	input  wire logic         busReadStrobe,
	input  wire logic         timer2ClkOutEn,
	input  wire logic         timer2ClkOut,
	input  wire logic         uartTxEn,
	input  wire logic         uartTxd,
	input  wire logic         powerDown,
	input  wire logic [W-1:0] openDrainPortIn,
	output logic [W-1:0]      openDrainPortOut,
	output logic [W-1:0]      openDrainPortOe,
	input  wire logic [W-1:0] secondQuasiPortIn,
	output logic [W-1:0]      secondQuasiPortOut,
	output logic [W-1:0]      secondQuasiPortOe,
	input  wire logic [W-1:0] highAddressPortIn,
	output logic [W-1:0]      highAddressPortOut,
	output logic [W-1:0]      highAddressPortOe,
	input  wire logic [W-1:0] specialFunctionPortIn,
	output logic [W-1:0]      specialFunctionPortOut,
	output logic [W-1:0]      specialFunctionPortOe,
	input  wire logic [3:0]   extraNibblePortIn,
	output logic [3:0]        extraNibblePortOut,
	output logic [3:0]        extraNibblePortOe,
	output logic [W-1:0]      openDrainPortPins,
	output logic [W-1:0]      secondQuasiPortPins,
	output logic [W-1:0]      highAddressPortPins,
	output logic [W-1:0]      specialFunctionPortPins,
	output logic [3:0]        extraNibblePortPins,
	output logic              timer2EventIn,
	output logic              timer2ExtControlIn,
	output logic              uartRxd,
	output logic              extIrq0In,
	output logic              extIrq1In,
	output logic              timer0EventIn,
	output logic              timer1EventIn,
	output logic              wakeUp
);
	////////////////////////////////////////////////////////////////////////////////
	// Port latches
	logic [W-1:0] lat0_q, lat1_q, lat2_q, lat3_q, lat0_d, lat1_d, lat2_d, lat3_d;
	logic [3:0]   lat4_q, lat4_d;
	always_comb begin
		lat0_d = lat0_q;
		lat1_d = lat1_q;
		lat2_d = lat2_q;
		lat3_d = lat3_q;
		lat4_d = nibbleWrite ? nibbleData : lat4_q;
		if (latchWrite) begin
			unique case (latchSel)
				2'h0: lat0_d = latchData;
				2'h1: lat1_d = latchData;
				2'h2: lat2_d = latchData;
				2'h3: lat3_d = latchData;
			endcase
		end
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			lat0_q <= port_pins_pkg::LATCH_RESET;
			lat1_q <= port_pins_pkg::LATCH_RESET;
			lat2_q <= port_pins_pkg::LATCH_RESET;
			lat3_q <= port_pins_pkg::LATCH_RESET;
			lat4_q <= port_pins_pkg::NIBBLE_RESET;
		end else begin
			lat0_q <= lat0_d;
			lat1_q <= lat1_d;
			lat2_q <= lat2_d;
			lat3_q <= lat3_d;
			lat4_q <= lat4_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Effective drive values including alternate functions
	logic [W-1:0] val1, val2, val3;
	logic [3:0]   val4;
	always_comb begin
		val1 = lat1_q;
		if (timer2ClkOutEn) val1[port_pins_pkg::BIT_T2] = timer2ClkOut; // [RQ5]
		val2 = extBusActive ? busAddrHigh : lat2_q; // [RQ4]
		val3 = lat3_q;
		if (uartTxEn) val3[port_pins_pkg::BIT_TXD] = lat3_q[port_pins_pkg::BIT_TXD] & uartTxd; // [RQ7]
		if (extDataAccess) begin
			val3[port_pins_pkg::BIT_WRN] = ~busWriteStrobe; // [RQ11]
			val3[port_pins_pkg::BIT_RDN] = ~busReadStrobe; // [RQ11]
		end
		val4 = lat4_q;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Quasi-bidirectional strong pulse counters, per bit
	localparam int NQ = 3 * W + 4;
	logic [NQ-1:0] qval, qprev_q, qprev_d, qstrong, qrise;
	logic [1:0]    cnt_q [NQ];
	logic [1:0]    cnt_d [NQ];
	assign qval = {val4, val3, val2, val1};
	// Strong drive starts in the cycle of the rising value
	assign qrise = qval & ~qprev_q; // [RQ3]
	genvar g;
	generate
		for (g = 0; g < NQ; g++) begin : gQuasi
			always_comb begin
				cnt_d[g] = (cnt_q[g] != 2'h0) ? cnt_q[g] - 2'h1 : 2'h0;
				if (qrise[g]) cnt_d[g] = port_pins_pkg::STRONG_CNT_W1; // [RQ3]
			end
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) cnt_q[g] <= 2'h0;
				else cnt_q[g] <= cnt_d[g];
			end
			assign qstrong[g] = qrise[g] | (cnt_q[g] != 2'h0); // [RQ3]
		end
	endgenerate
	assign qprev_d = qval;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) qprev_q <= {NQ{1'b1}};
		else qprev_q <= qprev_d;
	end

	// Low drives strongly; high drives only while the pulse runs, else weak pull-up
	logic [NQ-1:0] qoe;
	assign qoe = ~qval | qstrong; // [RQ3]
	assign secondQuasiPortOut     = val1;
	assign secondQuasiPortOe      = qoe[W-1:0];
	assign highAddressPortOut     = val2;
	assign highAddressPortOe      = qoe[2*W-1:W];
	assign specialFunctionPortOut = val3;
	assign specialFunctionPortOe  = qoe[3*W-1:2*W];
	assign extraNibblePortOut     = val4;
	assign extraNibblePortOe      = qoe[NQ-1:3*W];

	////////////////////////////////////////////////////////////////////////////////
	// Open-drain first port with muxed bus
	logic [W-1:0] val0;
	always_comb begin
		val0 = lat0_q; // [RQ1]
		if (extBusActive) val0 = busDataPhase ? (busDataDrive ? busDataOut : {W{1'b1}}) : busAddrLow; // [RQ2]
	end
	assign openDrainPortOut = val0;
	// Address and driven-data bus phases drive both levels, undriven data phase releases all; latch mode only pulls low
	assign openDrainPortOe  = extBusActive ? ((busDataPhase && !busDataDrive) ? '0 : {W{1'b1}}) : ~lat0_q; // [RQ1] [RQ2]

	////////////////////////////////////////////////////////////////////////////////
	// Pad sampling and alternate inputs
	logic [4*W+3:0] pad_q, pad_d;
	assign pad_d = {extraNibblePortIn, specialFunctionPortIn, highAddressPortIn, secondQuasiPortIn, openDrainPortIn};
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) pad_q <= '1;
		else pad_q <= pad_d; // [RQ12]
	end
	assign openDrainPortPins       = pad_q[W-1:0];
	assign secondQuasiPortPins     = pad_q[2*W-1:W];
	assign highAddressPortPins     = pad_q[3*W-1:2*W];
	assign specialFunctionPortPins = pad_q[4*W-1:3*W];
	assign extraNibblePortPins     = pad_q[4*W+3:4*W];
	assign timer2EventIn      = secondQuasiPortPins[port_pins_pkg::BIT_T2]; // [RQ5]
	assign timer2ExtControlIn = secondQuasiPortPins[port_pins_pkg::BIT_TIMER2_EXT_CONTROL_PIN]; // [RQ6]
	assign uartRxd            = specialFunctionPortPins[port_pins_pkg::BIT_RXD]; // [RQ7]
	assign extIrq0In          = specialFunctionPortPins[port_pins_pkg::BIT_IRQ0]; // [RQ10]
	assign extIrq1In          = specialFunctionPortPins[port_pins_pkg::BIT_IRQ1]; // [RQ10]
	assign timer0EventIn      = specialFunctionPortPins[port_pins_pkg::BIT_TMR0]; // [RQ10]
	assign timer1EventIn      = specialFunctionPortPins[port_pins_pkg::BIT_TMR1]; // [RQ10]
	// Active-low wake sources during power-down
	assign wakeUp = powerDown & ~(extIrq0In & extIrq1In & extraNibblePortPins[port_pins_pkg::BIT_WAKE2]
		& extraNibblePortPins[port_pins_pkg::BIT_WAKE3]); // [RQ9]
	assign machineCycleLen = sixClockMode ? port_pins_pkg::CYCLE_6 : port_pins_pkg::CYCLE_12; // [RQ8]

	////////////////////////////////////////////////////////////////////////////////
	// Assertions
	AST_OD_FLOAT: assert property (@(posedge sys_clk) disable iff (rst)
		!extBusActive |-> ((openDrainPortOe & lat0_q) == '0)) else $error("open-drain one driven"); // [RQ1]
	AST_ADDR_LOW: assert property (@(posedge sys_clk) disable iff (rst)
		(extBusActive && !busDataPhase) |-> (openDrainPortOut == busAddrLow && &openDrainPortOe))
		else $error("low address not on bus"); // [RQ2]
	AST_STRONG_TWO: assert property (@(posedge sys_clk) disable iff (rst)
		(!secondQuasiPortOut[2] ##1 secondQuasiPortOut[2] [*3]) |-> ($past(secondQuasiPortOe[2], 2)
		&& $past(secondQuasiPortOe[2]) && !secondQuasiPortOe[2])) else $error("strong pulse not two clocks"); // [RQ3]
	AST_HIGH_ADDR: assert property (@(posedge sys_clk) disable iff (rst)
		extBusActive |-> highAddressPortOut == busAddrHigh) else $error("high address missing"); // [RQ4]
	AST_T2_CLKOUT: assert property (@(posedge sys_clk) disable iff (rst)
		timer2ClkOutEn |-> secondQuasiPortOut[0] == timer2ClkOut) else $error("timer2 clock out wrong"); // [RQ5]
	AST_TIMER2_EXT_CONTROL_PIN_IN: assert property (@(posedge sys_clk) disable iff (rst)
		timer2ExtControlIn == $past(secondQuasiPortIn[1])) else $error("timer2 control input wrong"); // [RQ6]
	AST_UART_TX: assert property (@(posedge sys_clk) disable iff (rst)
		(uartTxEn && lat3_q[1]) |-> specialFunctionPortOut[1] == uartTxd) else $error("txd wrong"); // [RQ7]
	AST_CYCLE: assert property (@(posedge sys_clk) disable iff (rst)
		machineCycleLen == (sixClockMode ? 4'h6 : 4'hc)) else $error("machine cycle wrong"); // [RQ8]
	AST_WAKE: assert property (@(posedge sys_clk) disable iff (rst)
		(powerDown && !$past(specialFunctionPortIn[2])) |-> wakeUp) else $error("no wake"); // [RQ9]
	AST_STROBE: assert property (@(posedge sys_clk) disable iff (rst)
		(extDataAccess && busReadStrobe) |-> !specialFunctionPortOut[7]) else $error("read strobe missing"); // [RQ11]
	AST_PAD_READ: assert property (@(posedge sys_clk) disable iff (rst)
		highAddressPortPins == $past(highAddressPortIn)) else $error("pad read wrong"); // [RQ12]
	COV_BUS: cover property (@(posedge sys_clk) disable iff (rst) extBusActive && busDataPhase && busDataDrive);
	COV_PULSE: cover property (@(posedge sys_clk) disable iff (rst) $rose(secondQuasiPortOut[0]));
	COV_WAKE: cover property (@(posedge sys_clk) disable iff (rst) wakeUp);
endmodule

// ---- verif/pad_model.sv ----
`timescale 1ns/1ps
// Board side of one port: pull-ups on released lines, optional external low drive
module pad_model #(
	parameter int N = 8
) (
	input  wire logic [N-1:0] drvOut,
	input  wire logic [N-1:0] drvOe,
	input  wire logic [N-1:0] extLow,
	output logic [N-1:0]      pad
);
	// Driven bits follow the device, released bits float up unless pulled low
	always_comb begin
		for (int i = 0; i < N; i++) begin
			pad[i] = drvOe[i] ? drvOut[i] : ~extLow[i];
		end
	end
endmodule

// ---- verif/tb.sv ----
`timescale 1ns/1ps
module tb;
	logic       sys_clk = 1'b0, rst = 1'b1, sixClockMode = 1'b0, latchWrite = 1'b0, nibbleWrite = 1'b0;
	logic       extBusActive = 1'b0, busDataPhase = 1'b0, busDataDrive = 1'b0, extDataAccess = 1'b0;
	logic       busWriteStrobe = 1'b0, busReadStrobe = 1'b0, timer2ClkOutEn = 1'b0, timer2ClkOut = 1'b1;
	logic       uartTxEn = 1'b0, uartTxd = 1'b1, powerDown = 1'b0, wakeUp, uartRxd, extIrq0In, extIrq1In;
	logic       timer2EventIn, timer2ExtControlIn, timer0EventIn, timer1EventIn;
	logic [1:0] latchSel = 2'h0;
	logic [3:0] nibbleData = 4'hf, xnLow = 4'h0, machineCycleLen, extraNibblePortIn, extraNibblePortOut;
	logic [3:0] extraNibblePortOe, extraNibblePortPins;
	logic [7:0] latchData = 8'hff, busAddrLow = 8'h00, busAddrHigh = 8'h00, busDataOut = 8'h00;
	logic [7:0] odLow = 8'h00, sqLow = 8'h00, haLow = 8'h00, sfLow = 8'h00;
	logic [7:0] openDrainPortIn, openDrainPortOut, openDrainPortOe, openDrainPortPins;
	logic [7:0] secondQuasiPortIn, secondQuasiPortOut, secondQuasiPortOe, secondQuasiPortPins;
	logic [7:0] highAddressPortIn, highAddressPortOut, highAddressPortOe, highAddressPortPins;
	logic [7:0] specialFunctionPortIn, specialFunctionPortOut, specialFunctionPortOe, specialFunctionPortPins;
	int         errors = 0;
	int         testsRun = 0;

	always #12.5 sys_clk = ~sys_clk;

	quasi_bidir_port_pins dut (.*);
	pad_model #(.N(8)) p0 (.drvOut(openDrainPortOut), .drvOe(openDrainPortOe), .extLow(odLow), .pad(openDrainPortIn));
	pad_model #(.N(8)) p1 (.drvOut(secondQuasiPortOut), .drvOe(secondQuasiPortOe), .extLow(sqLow),
		.pad(secondQuasiPortIn));
	pad_model #(.N(8)) p2 (.drvOut(highAddressPortOut), .drvOe(highAddressPortOe), .extLow(haLow),
		.pad(highAddressPortIn));
	pad_model #(.N(8)) p3 (.drvOut(specialFunctionPortOut), .drvOe(specialFunctionPortOe), .extLow(sfLow),
		.pad(specialFunctionPortIn));
	pad_model #(.N(4)) p4 (.drvOut(extraNibblePortOut), .drvOe(extraNibblePortOe), .extLow(xnLow),
		.pad(extraNibblePortIn));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		testsRun++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [1:0] sel, input logic [7:0] d);
		@(posedge sys_clk);
		latchWrite <= 1'b1;
		latchSel <= sel;
		latchData <= d;
		@(posedge sys_clk);
		latchWrite <= 1'b0;
		@(negedge sys_clk);
	endtask

	task automatic wr_nib(input logic [3:0] d);
		@(posedge sys_clk);
		nibbleWrite <= 1'b1;
		nibbleData <= d;
		@(posedge sys_clk);
		nibbleWrite <= 1'b0;
		@(negedge sys_clk);
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_open_drain;
		chk(openDrainPortOe, 8'h00);
		chk(openDrainPortPins, 8'hff);
		wr(2'h0, 8'h5a);
		chk(openDrainPortOe, 8'ha5);
		chk(openDrainPortOut & openDrainPortOe, 8'h00);
		@(posedge sys_clk);
		odLow <= 8'h02;
		tick(2);
		chk(openDrainPortPins, 8'h58);
		@(posedge sys_clk);
		odLow <= 8'h00;
		wr(2'h0, 8'hff);
	endtask

	task automatic t_strong;
		wr(2'h1, 8'h00);
		chk(secondQuasiPortOe, 8'hff);
		wr(2'h1, 8'h0f);
		chk(secondQuasiPortOe, 8'hff);
		tick(1);
		chk(secondQuasiPortOe, 8'hff);
		tick(1);
		chk(secondQuasiPortOe, 8'hf0);
		chk(secondQuasiPortOut, 8'h0f);
	endtask

	task automatic t_gpio;
		wr(2'h2, 8'h81);
		chk(highAddressPortOut, 8'h81);
		chk(highAddressPortOe, 8'h7e);
		tick(1);
		chk(highAddressPortPins, 8'h81);
		wr(2'h2, 8'hff);
		wr(2'h3, 8'hfb);
		chk(specialFunctionPortOe, 8'h04);
		tick(1);
		chk(8'(extIrq0In), 8'h00);
		wr(2'h3, 8'hff);
	endtask

	task automatic t_nibble;
		wr_nib(4'h0);
		chk(8'(extraNibblePortOe), 8'h0f);
		chk(8'(extraNibblePortOut), 8'h00);
		wr_nib(4'h9);
		chk(8'(extraNibblePortOe), 8'h0f);
		tick(1);
		chk(8'(extraNibblePortOe), 8'h0f);
		tick(1);
		chk(8'(extraNibblePortOe), 8'h06);
		chk(8'(extraNibblePortPins), 8'h09);
		wr_nib(4'hf);
	endtask

	task automatic t_bus;
		@(posedge sys_clk);
		extBusActive <= 1'b1;
		busAddrLow <= 8'h3c;
		busAddrHigh <= 8'hc3;
		tick(1);
		chk(openDrainPortOut, 8'h3c);
		chk(openDrainPortOe, 8'hff);
		chk(highAddressPortOut, 8'hc3);
		chk(highAddressPortOe, 8'h3c);
		@(posedge sys_clk);
		busDataPhase <= 1'b1;
		busDataDrive <= 1'b1;
		busDataOut <= 8'ha7;
		tick(1);
		chk(openDrainPortOut, 8'ha7);
		@(posedge sys_clk);
		busDataDrive <= 1'b0;
		tick(1);
		chk(openDrainPortOe, 8'h00);
		@(posedge sys_clk);
		extBusActive <= 1'b0;
		tick(1);
		chk(highAddressPortOe, 8'h3c);
		tick(3);
		chk(highAddressPortOe, 8'h00);
		chk(highAddressPortOut, 8'hff);
	endtask

	task automatic t_alt;
		chk(8'(machineCycleLen), 8'h0c);
		@(posedge sys_clk);
		sixClockMode <= 1'b1;
		sqLow <= 8'h01;
		sfLow <= 8'h15;
		timer2ClkOutEn <= 1'b1;
		timer2ClkOut <= 1'b0;
		uartTxEn <= 1'b1;
		uartTxd <= 1'b0;
		extDataAccess <= 1'b1;
		busWriteStrobe <= 1'b1;
		tick(2);
		chk(8'(machineCycleLen), 8'h06);
		chk(8'({timer2EventIn, timer2ExtControlIn}), 8'h01);
		chk(8'({uartRxd, extIrq0In, extIrq1In, timer0EventIn, timer1EventIn}), 8'h05);
		chk(8'({secondQuasiPortOut[0], secondQuasiPortOe[0]}), 8'h01);
		chk(8'({specialFunctionPortOut[1], specialFunctionPortOe[1]}), 8'h01);
		chk(8'(specialFunctionPortOut[7:6]), 8'h02);
		chk(8'(wakeUp), 8'h00);
		@(posedge sys_clk);
		busWriteStrobe <= 1'b0;
		busReadStrobe <= 1'b1;
		powerDown <= 1'b1;
		tick(1);
		chk(8'(specialFunctionPortOut[7:6]), 8'h01);
		chk(8'(wakeUp), 8'h01);
		@(posedge sys_clk);
		sfLow <= 8'h00;
		xnLow <= 4'h4;
		tick(2);
		chk(8'(wakeUp), 8'h01);
		@(posedge sys_clk);
		xnLow <= 4'h0;
		tick(2);
		chk(8'(wakeUp), 8'h00);
	endtask

	task automatic tally_and_finish;
		if (errors == 0 && testsRun > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		#20000;
		errors++;
		tally_and_finish();
	end

	initial begin
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		tick(1);
		t_open_drain();
		t_strong();
		t_gpio();
		t_nibble();
		t_bus();
		t_alt();
		tally_and_finish();
	end
endmodule
